//--- design/dsb_pkg.sv
// Constants and types for the debug system bus access block
// How it works
// - No serial status when zero serial ports.
// - Valid flag per port, odd bits, upper zero.
// - Overflow flag below valid, cleared by zero.
// - Overflow set while full or write-when-full.
// - Address width picks address registers present.
// - No low address register at width zero.
// - Ignore bus register writes while busy.
// - Read bit loads address, starts sized read.
// - Low address field maps address 31:0.
// - High address needs width 33, maps 63:32.
// - No low data without any access size.
// - Write bit loads data, starts sized write.
// - Valid only after good read, cleared on start.
// - Low data field maps data 31:0.
// - High data needs 64/128 support, maps 63:32.
// - High data triggers force 64-bit access.
// - Halt summary recommended for many harts.
// - Summary bit n ORs harts 32n..32n+31.
// - Summary bit 33 ORs overflow flags.
// - Summary bit 32 ORs valid flags.
package dsb_pkg;
	localparam logic [4:0] OFS_SERIAL_FLAGS = 5'h15;
	localparam logic [4:0] OFS_ADDR_LOW = 5'h16;
	localparam logic [4:0] OFS_ADDR_HIGH = 5'h17;
	localparam logic [4:0] OFS_DATA_LOW = 5'h18;
	localparam logic [4:0] OFS_DATA_HIGH = 5'h19;
	localparam logic [4:0] OFS_HALT_SUMMARY = 5'h1b;
	localparam int DBUS_AW = 5;
	localparam int DBUS_DW = 34;
	localparam int BIT_BUSY = 33;
	localparam int BIT_READ = 32;
	localparam int SERIAL_PORTS = 8;
	localparam int HART_COUNT = 1024;
	localparam int HART_GROUP = 32;
	localparam int SUM_VALID_BIT = 32;
	localparam int SUM_FULL_BIT = 33;
	localparam int ABUS_SIZE = 64;
	localparam logic SUPPORTS_64B = 1'b1;
	localparam logic SUPPORTS_128B = 1'b0;
	localparam logic [2:0] SIZE_SUPPORT_LOW = 3'h7;
	localparam logic [DBUS_DW-1:0] REG_RESET = 34'h000000000;
	localparam logic [2:0] SIZE_64B = 3'h3;
	typedef enum logic [1:0] {
		DSB_IDLE = 2'b00,
		DSB_ISSUE = 2'b01,
		DSB_WAIT = 2'b10
	} dsb_state_t;
endpackage

//--- design/dsb_sys_if.sv
// Interface between the register front and the bus master engine
`timescale 1ns/1ps
interface dsb_sys_if;
	logic start;
	logic wr;
	logic [2:0] size;
	logic [63:0] addr;
	logic [63:0] wdata;
	logic done;
	logic ok;
	logic [63:0] rdata;
	modport front(output start, output wr, output size, output addr,
		output wdata, input done, input ok, input rdata);
	modport engine(input start, input wr, input size, input addr,
		input wdata, output done, output ok, output rdata);
endinterface

//--- design/dsb_serial_flag.sv
// One serial port's valid and sticky overflow flag pair
`timescale 1ns/1ps
module dsb_serial_flag
(
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_c2d_nonempty,
	input wire logic i_d2c_full,
	input wire logic i_wr_when_full,
	input wire logic i_clr,
	output logic o_valid,
	output logic o_ovf
);
	logic ovf_r;
	logic ovf_nxt;
	always_comb
	begin
		ovf_nxt = ovf_r;
		if (i_clr)
			ovf_nxt = 1'b0;
		if (i_d2c_full || i_wr_when_full)
			ovf_nxt = 1'b1;
	end
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
			ovf_r <= 1'b0;
		else
			ovf_r <= ovf_nxt;
	end
	assign o_valid = i_c2d_nonempty;
	assign o_ovf = ovf_r;
endmodule

//--- design/dsb_engine.sv
// System bus master engine: one access per start, busy until done
`timescale 1ns/1ps
module dsb_engine
(
	input wire logic i_mclk,
	input wire logic i_nrst,
	dsb_sys_if.engine sif,
	output logic o_sb_req,
	output logic o_sb_we,
	output logic [2:0] o_sb_size,
	output logic [63:0] o_sb_addr,
	output logic [63:0] o_sb_wdata,
	input wire logic i_sb_ack,
	input wire logic i_sb_err,
	input wire logic [63:0] i_sb_rdata
);
	import dsb_pkg::*;
	dsb_state_t st_r, st_nxt;
	logic req_r, req_nxt, we_r, we_nxt;
	logic [2:0] size_r, size_nxt;
	logic [63:0] addr_r, addr_nxt, wd_r, wd_nxt;
	always_comb
	begin
		st_nxt = st_r;
		req_nxt = req_r;
		we_nxt = we_r;
		size_nxt = size_r;
		addr_nxt = addr_r;
		wd_nxt = wd_r;
		case (st_r)
			DSB_IDLE:
				if (sif.start)
				begin
					st_nxt = DSB_ISSUE;
					we_nxt = sif.wr;
					size_nxt = sif.size;
					addr_nxt = sif.addr;
					wd_nxt = sif.wdata;
				end
			DSB_ISSUE:
			begin
				req_nxt = 1'b1;
				st_nxt = DSB_WAIT;
			end
			DSB_WAIT:
				if (i_sb_ack)
				begin
					req_nxt = 1'b0;
					st_nxt = DSB_IDLE;
				end
			default:
				st_nxt = DSB_IDLE;
		endcase
	end
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			st_r <= DSB_IDLE;
			req_r <= 1'b0;
			we_r <= 1'b0;
			size_r <= 3'h0;
			addr_r <= 64'h0;
			wd_r <= 64'h0;
		end
		else
		begin
			st_r <= st_nxt;
			req_r <= req_nxt;
			we_r <= we_nxt;
			size_r <= size_nxt;
			addr_r <= addr_nxt;
			wd_r <= wd_nxt;
		end
	end
	assign sif.done = (st_r == DSB_WAIT) && i_sb_ack;
	assign sif.ok = !i_sb_err;
	assign sif.rdata = i_sb_rdata;
	assign o_sb_req = req_r;
	assign o_sb_we = we_r;
	assign o_sb_size = size_r;
	assign o_sb_addr = addr_r;
	assign o_sb_wdata = wd_r;
endmodule

//--- design/dsb_top.sv
// Debug bus registers for system bus access, serial status, halt summary
`timescale 1ns/1ps
module dsb_top
(
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_dbus_wr,
	input wire logic i_dbus_rd,
	input wire logic [dsb_pkg::DBUS_AW-1:0] i_dbus_addr,
	input wire logic [dsb_pkg::DBUS_DW-1:0] i_dbus_wdata,
	output logic [dsb_pkg::DBUS_DW-1:0] o_dbus_rdata,
	input wire logic [2:0] i_access_size,
	input wire logic [dsb_pkg::SERIAL_PORTS-1:0] i_c2d_nonempty,
	input wire logic [dsb_pkg::SERIAL_PORTS-1:0] i_d2c_full,
	input wire logic [dsb_pkg::SERIAL_PORTS-1:0] i_wr_when_full,
	input wire logic [dsb_pkg::HART_COUNT-1:0] i_halted,
	output logic o_sb_req,
	output logic o_sb_we,
	output logic [2:0] o_sb_size,
	output logic [63:0] o_sb_addr,
	output logic [63:0] o_sb_wdata,
	input wire logic i_sb_ack,
	input wire logic i_sb_err,
	input wire logic [63:0] i_sb_rdata
);
	import dsb_pkg::*;
	dsb_sys_if sif();
	logic [63:0] addr_r, addr_nxt, data_r, data_nxt;
	logic busy_r, busy_nxt, valid_r, valid_nxt, rdpend_r, rdpend_nxt;
	logic [DBUS_DW-1:0] rdata_r, rdata_nxt;
	logic [SERIAL_PORTS-1:0] sval, sovf, sclr;
	logic [DBUS_DW-1:0] ser_word;
	logic [31:0] grp_or;
	logic wr_ok;
	logic start;
	logic start_wr;
	logic force64;
	localparam logic HAS_SERIAL = (SERIAL_PORTS != 0);
	localparam logic HAS_ALOW = (ABUS_SIZE != 0);
	localparam logic HAS_AHIGH = (ABUS_SIZE >= 33);
	localparam logic HAS_DLOW =
		(SIZE_SUPPORT_LOW != 3'h0) || SUPPORTS_64B || SUPPORTS_128B;
	localparam logic HAS_DHIGH = SUPPORTS_64B || SUPPORTS_128B;

	genvar g;
	generate
		for (g = 0; g < SERIAL_PORTS; g++)
		begin : g_ser
			dsb_serial_flag u_flag (
				.i_mclk(i_mclk),
				.i_nrst(i_nrst),
				.i_c2d_nonempty(i_c2d_nonempty[g]),
				.i_d2c_full(i_d2c_full[g]),
				.i_wr_when_full(i_wr_when_full[g]),
				.i_clr(sclr[g]),
				.o_valid(sval[g]),
				.o_ovf(sovf[g])
			);
			assign sclr[g] = i_dbus_wr && HAS_SERIAL &&
				(i_dbus_addr == OFS_SERIAL_FLAGS) &&
				!i_dbus_wdata[2*g];
			assign ser_word[2*g+1] = sval[g];
			assign ser_word[2*g] = sovf[g];
		end
		for (g = 0; g < HART_COUNT / HART_GROUP; g++)
		begin : g_sum
			assign grp_or[g] =
				|i_halted[g*HART_GROUP +: HART_GROUP];
		end
	endgenerate
	assign ser_word[DBUS_DW-1:2*SERIAL_PORTS] = '0;

	dsb_engine u_eng (
		.i_mclk(i_mclk),
		.i_nrst(i_nrst),
		.sif(sif),
		.o_sb_req(o_sb_req),
		.o_sb_we(o_sb_we),
		.o_sb_size(o_sb_size),
		.o_sb_addr(o_sb_addr),
		.o_sb_wdata(o_sb_wdata),
		.i_sb_ack(i_sb_ack),
		.i_sb_err(i_sb_err),
		.i_sb_rdata(i_sb_rdata)
	);

	always_comb
	begin
		addr_nxt = addr_r;
		data_nxt = data_r;
		busy_nxt = busy_r;
		valid_nxt = valid_r;
		rdpend_nxt = rdpend_r;
		start = 1'b0;
		start_wr = 1'b0;
		force64 = 1'b0;
		wr_ok = i_dbus_wr && !busy_r;
		if (wr_ok)
		begin
			if (HAS_ALOW && i_dbus_addr == OFS_ADDR_LOW)
			begin
				addr_nxt[31:0] = i_dbus_wdata[31:0];
				start = i_dbus_wdata[BIT_READ];
			end
			else if (HAS_AHIGH && i_dbus_addr == OFS_ADDR_HIGH)
			begin
				addr_nxt[63:32] = i_dbus_wdata[31:0];
				start = i_dbus_wdata[BIT_READ];
			end
			else if (HAS_DLOW && i_dbus_addr == OFS_DATA_LOW)
			begin
				data_nxt[31:0] = i_dbus_wdata[31:0];
				start_wr = i_dbus_wdata[BIT_BUSY];
				start = i_dbus_wdata[BIT_BUSY] || i_dbus_wdata[BIT_READ];
			end
			else if (HAS_DHIGH && i_dbus_addr == OFS_DATA_HIGH)
			begin
				data_nxt[63:32] = i_dbus_wdata[31:0];
				start_wr = i_dbus_wdata[BIT_BUSY];
				start = i_dbus_wdata[BIT_BUSY] || i_dbus_wdata[BIT_READ];
				force64 = 1'b1;
			end
		end
		if (start)
		begin
			busy_nxt = 1'b1;
			valid_nxt = 1'b0;
			rdpend_nxt = !start_wr;
		end
		if (busy_r && sif.done)
		begin
			busy_nxt = 1'b0;
			rdpend_nxt = 1'b0;
			if (rdpend_r && sif.ok)
			begin
				data_nxt = sif.rdata;
				valid_nxt = 1'b1;
			end
		end
	end
	assign sif.start = start;
	assign sif.wr = start_wr;
	assign sif.size = force64 ? SIZE_64B : i_access_size;
	assign sif.addr = addr_nxt;
	assign sif.wdata = data_nxt;

	always_comb
	begin
		rdata_nxt = rdata_r;
		if (i_dbus_rd)
		begin
			rdata_nxt = '0;
			if (HAS_SERIAL && i_dbus_addr == OFS_SERIAL_FLAGS)
				rdata_nxt = ser_word;
			else if (HAS_ALOW && i_dbus_addr == OFS_ADDR_LOW)
				rdata_nxt = {busy_r, 1'b0, addr_r[31:0]};
			else if (HAS_AHIGH && i_dbus_addr == OFS_ADDR_HIGH)
				rdata_nxt = {busy_r, 1'b0, addr_r[63:32]};
			else if (HAS_DLOW && i_dbus_addr == OFS_DATA_LOW)
				rdata_nxt = {busy_r, valid_r, data_r[31:0]};
			else if (HAS_DHIGH && i_dbus_addr == OFS_DATA_HIGH)
				rdata_nxt = {busy_r, valid_r, data_r[63:32]};
			else if (i_dbus_addr == OFS_HALT_SUMMARY)
			begin
				rdata_nxt[31:0] = grp_or;
				rdata_nxt[SUM_VALID_BIT] = |sval;
				rdata_nxt[SUM_FULL_BIT] = |sovf;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			addr_r <= 64'h0;
			data_r <= 64'h0;
			busy_r <= 1'b0;
			valid_r <= 1'b0;
			rdpend_r <= 1'b0;
			rdata_r <= REG_RESET;
		end
		else
		begin
			addr_r <= addr_nxt;
			data_r <= data_nxt;
			busy_r <= busy_nxt;
			valid_r <= valid_nxt;
			rdpend_r <= rdpend_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	assign o_dbus_rdata = rdata_r;
endmodule

//--- testbench/dsb_chk.sv
// Port checker for the system bus access block
`timescale 1ns/1ps
module dsb_chk
(
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_dbus_wr,
	input wire logic i_dbus_rd,
	input wire logic [4:0] i_dbus_addr,
	input wire logic [33:0] i_dbus_wdata,
	input wire logic [33:0] o_dbus_rdata,
	input wire logic [2:0] i_access_size,
	input wire logic [1023:0] i_halted,
	input wire logic o_sb_req,
	input wire logic o_sb_we,
	input wire logic [2:0] o_sb_size,
	input wire logic [63:0] o_sb_addr,
	input wire logic [63:0] o_sb_wdata,
	input wire logic i_sb_ack
);
	import dsb_pkg::*;
	logic bsy_r;
	logic go;
	logic [31:0] hs;
	assign go = i_dbus_wr && !bsy_r && (i_dbus_addr inside {5'h16, 5'h17} ?
		i_dbus_wdata[32] :
		i_dbus_addr inside {5'h18, 5'h19} && |i_dbus_wdata[33:32]);
	always_comb
		for (int g = 0; g < 32; g++)
			hs[g] = |i_halted[g*32 +: 32];
	always_ff @(posedge i_mclk or negedge i_nrst)
		if (!i_nrst)
			bsy_r <= 1'b0;
		else if (o_sb_req && i_sb_ack)
			bsy_r <= 1'b0;
		else if (go)
			bsy_r <= 1'b1;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	chk_rd_start: assert property (go && i_dbus_addr == 5'h16 |-> ##2
		o_sb_req && !o_sb_we && o_sb_size == $past(i_access_size, 2) &&
		o_sb_addr[31:0] == $past(i_dbus_wdata[31:0], 2)) else $error("rd");
	chk_hi_size: assert property (go && i_dbus_addr == 5'h19 |-> ##2
		o_sb_req && o_sb_size == 3'h3) else $error("size");
	chk_wr_start: assert property (go && i_dbus_addr == 5'h18 &&
		i_dbus_wdata[33] |-> ##2 o_sb_req && o_sb_we &&
		o_sb_size == $past(i_access_size, 2) &&
		o_sb_wdata[31:0] == $past(i_dbus_wdata[31:0], 2)) else $error("wr");
	chk_busy_ign: assert property (o_sb_req && !i_sb_ack |=> o_sb_req &&
		$stable(o_sb_addr) && $stable(o_sb_wdata)) else $error("busy");
	chk_req_drop: assert property (o_sb_req && i_sb_ack |=>
		!o_sb_req [*2]) else $error("drop");
	chk_busy_bit: assert property (i_dbus_rd && i_dbus_addr inside
		{5'h16, 5'h17, 5'h18} |=> o_dbus_rdata[33] == $past(bsy_r))
		else $error("busy bit");
	chk_halt_sum: assert property (i_dbus_rd && i_dbus_addr == 5'h1b
		|=> o_dbus_rdata[31:0] == $past(hs)) else $error("sum");
	chk_ser_zero: assert property (i_dbus_rd && i_dbus_addr == 5'h15
		|=> o_dbus_rdata[33:16] == 18'h0) else $error("ser");
endmodule
bind dsb_top dsb_chk chk_u (.i_mclk, .i_nrst, .i_dbus_wr, .i_dbus_rd,
	.i_dbus_addr, .i_dbus_wdata, .o_dbus_rdata, .i_access_size, .i_halted,
	.o_sb_req, .o_sb_we, .o_sb_size, .o_sb_addr, .o_sb_wdata, .i_sb_ack);

//--- testbench/dsb_sb_mem.sv
// System bus responder with adjustable wait and error reply
`timescale 1ns/1ps
module dsb_sb_mem
(
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic [63:0] i_addr,
	input wire logic [63:0] i_wdata,
	input wire logic [3:0] i_dly,
	input wire logic i_err,
	output logic o_ack,
	output logic o_err,
	output logic [63:0] o_rdata
);
	logic [63:0] mem_r;
	logic [3:0] cnt_r;
	logic hit;
	assign hit = i_req && !o_ack && cnt_r == i_dly;
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			mem_r <= 64'h0123456789abcdef;
			cnt_r <= 4'h0;
			o_ack <= 1'b0;
			o_err <= 1'b0;
			o_rdata <= 64'h0;
		end
		else
		begin
			o_ack <= hit;
			o_err <= hit && i_err;
			cnt_r <= (i_req && !o_ack) ? cnt_r + 4'h1 : 4'h0;
			o_rdata <= hit ? mem_r ^ i_addr : ~o_rdata;
			if (hit && i_we && !i_err)
				mem_r <= i_wdata;
		end
	end
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the system bus access block
`timescale 1ns/1ps
module testbench;
	import dsb_pkg::*;
	typedef struct packed
	{
		logic [1:0] op;
		logic [4:0] a;
		logic [33:0] d;
	} dsb_row_t;
	logic i_mclk, i_nrst, i_dbus_wr, i_dbus_rd, i_sb_ack, i_sb_err, err_en;
	logic o_sb_req, o_sb_we;
	logic [4:0] i_dbus_addr;
	logic [33:0] i_dbus_wdata, o_dbus_rdata, rv;
	logic [2:0] i_access_size, o_sb_size;
	logic [7:0] i_c2d_nonempty, i_d2c_full, i_wr_when_full;
	logic [1023:0] i_halted;
	logic [63:0] o_sb_addr, o_sb_wdata, i_sb_rdata;
	logic [3:0] dly;
	int fails, tests_run, cyc;
	dsb_row_t rows [0:35] = '{'{2'h0, 5'h15, 34'h0}, '{2'h0, 5'h16, 34'h0},
		'{2'h0, 5'h19, 34'h0}, '{2'h0, 5'h1a, 34'h0}, '{2'h0, 5'h1b, 34'h0},
		'{2'h1, 5'h17, 34'h011111111}, '{2'h1, 5'h16, 34'h122222222},
		'{2'h2, 5'h0, 34'h0}, '{2'h0, 5'h18, 34'h1ab89efcd},
		'{2'h0, 5'h19, 34'h110325476}, '{2'h0, 5'h17, 34'h011111111},
		'{2'h1, 5'h19, 34'h0aaaaaaaa}, '{2'h1, 5'h18, 34'h255555555},
		'{2'h2, 5'h0, 34'h0}, '{2'h0, 5'h18, 34'h055555555},
		'{2'h1, 5'h19, 34'h1aaaaaaaa}, '{2'h2, 5'h0, 34'h0},
		'{2'h0, 5'h18, 34'h177777777}, '{2'h0, 5'h19, 34'h1bbbbbbbb},
		'{2'h1, 5'h17, 34'h1ffffffff}, '{2'h2, 5'h0, 34'h0},
		'{2'h0, 5'h19, 34'h155555555}, '{2'h1, 5'h18, 34'h100000000},
		'{2'h2, 5'h0, 34'h0}, '{2'h0, 5'h18, 34'h177777777},
		'{2'h1, 5'h19, 34'h2dddddddd}, '{2'h2, 5'h0, 34'h0},
		'{2'h0, 5'h19, 34'h0dddddddd},
		'{2'h3, 5'h0, 34'h1a}, '{2'h1, 5'h16, 34'h133333333},
		'{2'h1, 5'h16, 34'h144444444}, '{2'h1, 5'h18, 34'h299999999},
		'{2'h2, 5'h0, 34'h0}, '{2'h0, 5'h16, 34'h033333333},
		'{2'h0, 5'h18, 34'h144444444}, '{2'h3, 5'h0, 34'h0}};
	dsb_top dut_u (.i_mclk, .i_nrst, .i_dbus_wr, .i_dbus_rd, .i_dbus_addr,
		.i_dbus_wdata, .o_dbus_rdata, .i_access_size, .i_c2d_nonempty,
		.i_d2c_full, .i_wr_when_full, .i_halted, .o_sb_req, .o_sb_we,
		.o_sb_size, .o_sb_addr, .o_sb_wdata, .i_sb_ack, .i_sb_err, .i_sb_rdata);
	dsb_sb_mem mem_u (.i_mclk, .i_nrst, .i_req(o_sb_req), .i_we(o_sb_we),
		.i_addr(o_sb_addr), .i_wdata(o_sb_wdata), .i_dly(dly), .i_err(err_en),
		.o_ack(i_sb_ack), .o_err(i_sb_err), .o_rdata(i_sb_rdata));
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [33:0] s, input logic [33:0] e);
		tests_run++;
		if (s !== e)
		begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task wr(input logic [4:0] a, input logic [33:0] d);
		@(posedge i_mclk);
		i_dbus_wr <= 1'b1;
		i_dbus_addr <= a;
		i_dbus_wdata <= d;
		@(posedge i_mclk);
		i_dbus_wr <= 1'b0;
	endtask
	task rd(input logic [4:0] a);
		@(posedge i_mclk);
		i_dbus_rd <= 1'b1;
		i_dbus_addr <= a;
		@(posedge i_mclk);
		i_dbus_rd <= 1'b0;
		@(negedge i_mclk);
		rv = o_dbus_rdata;
	endtask
	task idle;
		int n;
		n = 0;
		do
		begin
			rd(5'h16);
			n++;
		end
		while (rv[33] !== 1'b0 && n < 100);
		chk({33'h0, rv[33]}, 34'h0);
	endtask
	initial
	begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			report_and_stop;
		end
	end
	initial
	begin
		{i_nrst, i_dbus_wr, i_dbus_rd, err_en, i_dbus_addr, i_dbus_wdata} = '0;
		{i_c2d_nonempty, i_d2c_full, i_wr_when_full, i_halted} = '0;
		{fails, tests_run, cyc} = '0;
		i_access_size = 3'h2;
		dly = 4'h1;
		repeat (4) @(posedge i_mclk);
		i_nrst <= 1'b1;
		foreach (rows[k])
		begin
			if (rows[k].op == 2'h0)
				rd(rows[k].a);
			if (rows[k].op == 2'h0)
				chk(rv, rows[k].d);
			if (rows[k].op == 2'h1)
				wr(rows[k].a, rows[k].d);
			if (rows[k].op == 2'h2)
				idle;
			if (rows[k].op == 2'h3)
			begin
				@(posedge i_mclk);
				dly <= rows[k].d[3:0];
				i_access_size <= rows[k].d[6:4];
			end
		end
		@(posedge i_mclk);
		err_en <= 1'b1;
		wr(5'h16, 34'h100000000);
		idle;
		rd(5'h18);
		chk({33'h0, rv[32]}, 34'h0);
		@(posedge i_mclk);
		err_en <= 1'b0;
		i_c2d_nonempty <= 8'h81;
		i_d2c_full <= 8'h02;
		i_wr_when_full <= 8'h08;
		i_halted <= {1'b1, 990'h0, 1'b1, 32'h0};
		@(posedge i_mclk);
		i_wr_when_full <= 8'h00;
		rd(5'h15);
		chk(rv, 34'h8046);
		rd(5'h1b);
		chk(rv, 34'h380000002);
		wr(5'h15, 34'h0);
		rd(5'h15);
		chk(rv, 34'h8006);
		@(posedge i_mclk);
		i_d2c_full <= 8'h00;
		i_c2d_nonempty <= 8'h00;
		wr(5'h15, 34'h0);
		rd(5'h1b);
		chk(rv, 34'h080000002);
		@(posedge i_mclk);
		dly <= 4'hf;
		wr(5'h16, 34'h1a5a5a5a5);
		repeat (2) @(posedge i_mclk);
		@(negedge i_mclk);
		chk({33'h0, o_sb_req}, 34'h1);
		@(posedge i_mclk);
		i_nrst <= 1'b0;
		@(negedge i_mclk);
		chk({33'h0, o_sb_req}, 34'h0);
		chk(o_dbus_rdata, 34'h0);
		@(posedge i_mclk);
		i_nrst <= 1'b1;
		rd(5'h16);
		chk(rv, 34'h0);
		rd(5'h18);
		chk(rv, 34'h0);
		report_and_stop;
	end
endmodule
